/* File: rtl/ctl_bus_pkg.sv */
// Constants, types and helpers for the serial control bus slave port
`default_nettype none
package ctl_bus_pkg;
  // Strap-selected bus addresses
  localparam logic [6:0] ADDR_SEL_00     = 7'h3c;
  localparam logic [6:0] ADDR_SEL_01     = 7'h3d;
  localparam logic [6:0] ADDR_SEL_10     = 7'h36;
  localparam logic [6:0] ADDR_SEL_11     = 7'h37;
  // Reset of the programmed address field, held by the register file outside
  localparam logic [6:0] PROG_ADDR_RESET = 7'h30;
  localparam logic [7:0] INDEX_RESET     = 8'h00;
  localparam logic [3:0] ACK_SLOT        = 4'h8;
  // Bus rates against the system clock
  localparam int         CLK_SYS_KHZ     = 200000;
  localparam int         STD_MODE_KHZ    = 100;
  localparam int         FAST_MODE_KHZ   = 400;
  localparam int         FAST_OVERSAMPLE = CLK_SYS_KHZ / FAST_MODE_KHZ;

  typedef enum logic [2:0] {ST_ADDR, ST_INDEX, ST_WDATA, ST_RDATA, ST_IGNORE} link_state_t;

  typedef struct packed {
    logic [7:0] index;
    logic [7:0] data;
  } reg_wr_t;

  // Strap pins to bus address
  function automatic logic [6:0] strapAddr(input logic [1:0] sel);
    case (sel)
      2'h0:    strapAddr = ADDR_SEL_00;
      2'h1:    strapAddr = ADDR_SEL_01;
      2'h2:    strapAddr = ADDR_SEL_10;
      default: strapAddr = ADDR_SEL_11;
    endcase
  endfunction
endpackage
`default_nettype wire

/* File: rtl/control_bus_slave_port.sv */
// Serial control bus slave port: framing, acknowledge, index and register access
// Behaviour
// - Strap pins pick one of four addresses.
// - START/STOP framed by SDA edge, SCL high.
// - Acknowledge own address, release on mismatch.
// - Write: index byte, then data bytes.
// - Acknowledge write bytes, advance index each.
// - Read address acknowledged, byte shifted out.
// - Master ACK continues, NACK ends read.
// - Standard and fast mode, 8-bit.
// - Current-location read uses retained index.
// - Lines only pulled low, never driven high.
// - Register bit selects programmed address source.
`timescale 1ns/1ps
`default_nettype none
module control_bus_slave_port
(
  input  wire  logic                 clk_sys,
  input  wire  logic                 rstn,
  input  wire  logic                 sclClk,
  input  wire  logic                 sdaIn,
  output logic                       sdaOut,
  output logic                       sdaOe,
  input  wire  logic [1:0]           addrSelectPins,
  input  wire  logic                 addrSourceFromRegister,
  input  wire  logic [6:0]           programmedBusAddress,
  output logic                       regWrEn,
  output ctl_bus_pkg::reg_wr_t       regWr,
  output logic                       regRdEn,
  output logic [7:0]                 regRdIndex,
  input  wire  logic [7:0]           regRdData
);
  import ctl_bus_pkg::*;
  // System-domain state
  logic        sclMeta_reg, sclMeta_next, sclSmp_reg, sclSmp_next;
  logic        sdaMeta_reg, sdaMeta_next, sdaSmp_reg, sdaSmp_next, sdaPrev_reg, sdaPrev_next;
  logic [1:0]  pinMeta_reg, pinMeta_next, pinSmp_reg, pinSmp_next;
  logic [6:0]  ownAddr_reg, ownAddr_next;
  logic        frameHold_reg, frameHold_next;
  logic        wrMeta_reg, wrMeta_next, wrSmp_reg, wrSmp_next, wrPrev_reg, wrPrev_next;
  logic        rdMeta_reg, rdMeta_next, rdSmp_reg, rdSmp_next, rdPrev_reg, rdPrev_next;
  logic        regWrEn_reg, regWrEn_next, regRdEn_reg, regRdEn_next;
  reg_wr_t     regWr_reg, regWr_next;
  logic [7:0]  regRdIndex_reg, regRdIndex_next, rdHold_reg, rdHold_next;
  logic        busStart, busStop;
  // Link-domain state
  link_state_t state_reg, state_next;
  logic [3:0]  bitCnt_reg, bitCnt_next;
  logic [7:0]  shift_reg, shift_next, index_reg, index_next;
  logic        wrTgl_reg, wrTgl_next, rdTgl_reg, rdTgl_next;
  reg_wr_t     wrHold_reg, wrHold_next;
  logic [7:0]  rdIndexHold_reg, rdIndexHold_next, txByte_reg, txByte_next, curByte;
  logic        sdaOe_reg, sdaOe_next, addrHit, linkRstN;
  // Address compare, used by both link edges
  function automatic logic hitF(input logic [7:0] b, input logic [6:0] own);
    hitF = (b[7:1] == own);
  endfunction
  // Conditions seen on synchronised pins; 500 samples per fast-mode bit
  assign busStart = sclSmp_reg & sdaPrev_reg & ~sdaSmp_reg;
  assign busStop  = sclSmp_reg & ~sdaPrev_reg & sdaSmp_reg;
  // Pin sync, address choice and frame hold
  always_comb
  begin
    sclMeta_next = sclClk;
    sclSmp_next  = sclMeta_reg;
    sdaMeta_next = sdaIn;
    sdaSmp_next  = sdaMeta_reg;
    sdaPrev_next = sdaSmp_reg;
    pinMeta_next = addrSelectPins;
    pinSmp_next  = pinMeta_reg;
    ownAddr_next = addrSourceFromRegister ? programmedBusAddress : strapAddr(pinSmp_reg);
    // Hold link logic idle from START/STOP until SCL falls, so every frame starts clean
    frameHold_next = frameHold_reg;
    if (busStart || busStop)
      frameHold_next = 1'b1;
    else if (!sclSmp_reg)
      frameHold_next = 1'b0;
  end
  // Toggle crossings into register-side strobes; hold words are stable by then
  always_comb
  begin
    wrMeta_next     = wrTgl_reg;
    wrSmp_next      = wrMeta_reg;
    wrPrev_next     = wrSmp_reg;
    rdMeta_next     = rdTgl_reg;
    rdSmp_next      = rdMeta_reg;
    rdPrev_next     = rdSmp_reg;
    regWrEn_next    = wrSmp_reg ^ wrPrev_reg;
    regWr_next      = regWrEn_next ? wrHold_reg : regWr_reg;
    regRdEn_next    = rdSmp_reg ^ rdPrev_reg;
    regRdIndex_next = regRdEn_next ? rdIndexHold_reg : regRdIndex_reg;
    rdHold_next     = regRdEn_reg ? regRdData : rdHold_reg;
  end
  // System-domain registers
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      {sclMeta_reg, sclSmp_reg, sdaMeta_reg, sdaSmp_reg, sdaPrev_reg} <= 5'h1f;
      {pinMeta_reg, pinSmp_reg} <= 4'h0;
      ownAddr_reg    <= ADDR_SEL_00;
      frameHold_reg  <= 1'b1;
      {wrMeta_reg, wrSmp_reg, wrPrev_reg, rdMeta_reg, rdSmp_reg, rdPrev_reg} <= 6'h00;
      {regWrEn_reg, regRdEn_reg} <= 2'h0;
      regWr_reg      <= '0;
      regRdIndex_reg <= INDEX_RESET;
      rdHold_reg     <= 8'h00;
    end
    else
    begin
      {sclMeta_reg, sclSmp_reg, sdaMeta_reg, sdaSmp_reg, sdaPrev_reg} <=
        {sclMeta_next, sclSmp_next, sdaMeta_next, sdaSmp_next, sdaPrev_next};
      {pinMeta_reg, pinSmp_reg} <= {pinMeta_next, pinSmp_next};
      ownAddr_reg    <= ownAddr_next;
      frameHold_reg  <= frameHold_next;
      {wrMeta_reg, wrSmp_reg, wrPrev_reg, rdMeta_reg, rdSmp_reg, rdPrev_reg} <=
        {wrMeta_next, wrSmp_next, wrPrev_next, rdMeta_next, rdSmp_next, rdPrev_next};
      {regWrEn_reg, regRdEn_reg} <= {regWrEn_next, regRdEn_next};
      regWr_reg      <= regWr_next;
      regRdIndex_reg <= regRdIndex_next;
      rdHold_reg     <= rdHold_next;
    end
  end
  assign regWrEn    = regWrEn_reg;
  assign regWr      = regWr_reg;
  assign regRdEn    = regRdEn_reg;
  assign regRdIndex = regRdIndex_reg;
  assign linkRstN   = rstn & ~frameHold_reg;
  assign addrHit    = hitF(shift_reg, ownAddr_reg);
  // Rising SCL: sample bits, act on the acknowledge slot
  always_comb
  begin
    state_next       = state_reg;
    bitCnt_next      = bitCnt_reg;
    shift_next       = shift_reg;
    index_next       = index_reg;
    wrTgl_next       = wrTgl_reg;
    wrHold_next      = wrHold_reg;
    rdTgl_next       = rdTgl_reg;
    rdIndexHold_next = rdIndexHold_reg;
    if (bitCnt_reg != ACK_SLOT)
    begin
      shift_next  = {shift_reg[6:0], sdaIn};
      bitCnt_next = bitCnt_reg + 4'h1;
    end
    else
    begin
      bitCnt_next = 4'h0;
      case (state_reg)
        ST_ADDR:
        begin
          if (!addrHit)
            state_next = ST_IGNORE;
          else if (shift_reg[0])
          begin
            state_next       = ST_RDATA; // Read from retained index
            rdIndexHold_next = index_reg;
            rdTgl_next       = ~rdTgl_reg;
          end
          else
            state_next = ST_INDEX;
        end
        ST_INDEX:
        begin
          index_next = shift_reg;
          state_next = ST_WDATA;
        end
        ST_WDATA:
        begin
          wrHold_next = '{index: index_reg, data: shift_reg};
          wrTgl_next  = ~wrTgl_reg;
          index_next  = index_reg + 8'h01;
        end
        ST_RDATA:
        begin
          index_next = index_reg + 8'h01;
          if (sdaIn)
            state_next = ST_IGNORE;
          else
          begin
            rdIndexHold_next = index_reg + 8'h01;
            rdTgl_next       = ~rdTgl_reg;
          end
        end
        default: state_next = ST_IGNORE;
      endcase
    end
  end
  // Frame state, cleared by every START/STOP hold
  always_ff @(posedge sclClk or negedge linkRstN)
  begin
    if (!linkRstN)
    begin
      state_reg  <= ST_ADDR;
      bitCnt_reg <= 4'h0;
      shift_reg  <= 8'h00;
    end
    else
    begin
      state_reg  <= state_next;
      bitCnt_reg <= bitCnt_next;
      shift_reg  <= shift_next;
    end
  end
  // Retained across frames: index and crossing words
  always_ff @(posedge sclClk or negedge rstn)
  begin
    if (!rstn)
    begin
      index_reg       <= INDEX_RESET;
      wrTgl_reg       <= 1'b0;
      wrHold_reg      <= '0;
      rdTgl_reg       <= 1'b0;
      rdIndexHold_reg <= INDEX_RESET;
    end
    else
    begin
      index_reg       <= index_next;
      wrTgl_reg       <= wrTgl_next;
      wrHold_reg      <= wrHold_next;
      rdTgl_reg       <= rdTgl_next;
      rdIndexHold_reg <= rdIndexHold_next;
    end
  end
  // Falling SCL: drive ACK or read bits; rdHold settles within SCL high time
  always_comb
  begin
    curByte     = (bitCnt_reg == 4'h0) ? rdHold_reg : txByte_reg;
    txByte_next = curByte;
    sdaOe_next  = 1'b0;
    if (bitCnt_reg == ACK_SLOT)
      sdaOe_next = ((state_reg == ST_ADDR) && addrHit) || (state_reg == ST_INDEX) ||
                   (state_reg == ST_WDATA);
    else if (state_reg == ST_RDATA)
      sdaOe_next = ~curByte[~bitCnt_reg[2:0]];
  end
  // Launch on falling SCL so SDA is steady while SCL is high
  always_ff @(negedge sclClk or negedge linkRstN)
  begin
    if (!linkRstN)
    begin
      sdaOe_reg  <= 1'b0;
      txByte_reg <= 8'h00;
    end
    else
    begin
      sdaOe_reg  <= sdaOe_next;
      txByte_reg <= txByte_next;
    end
  end
  // Only ever pull low; a one is a released line
  assign sdaOut = 1'b0;
  assign sdaOe  = sdaOe_reg;
  // Checks; START/STOP must leave the frame logic reset and SDA released
  a_start_holds: assert property (@(posedge clk_sys) disable iff (!rstn)
    busStart |=> frameHold_reg && state_reg == ST_ADDR && bitCnt_reg == 4'h0 && !sdaOe_reg)
    else $error("START did not hold link");
  a_stop_holds: assert property (@(posedge clk_sys) disable iff (!rstn)
    busStop |=> frameHold_reg && state_reg == ST_ADDR && bitCnt_reg == 4'h0 && !sdaOe_reg)
    else $error("STOP did not hold link");
  a_strap_addr: assert property (@(posedge clk_sys) disable iff (!rstn)
    (!addrSourceFromRegister && pinSmp_reg == 2'h2) |=> ownAddr_reg == ADDR_SEL_10)
    else $error("strap address wrong");
  a_prog_addr: assert property (@(posedge clk_sys) disable iff (!rstn)
    addrSourceFromRegister |=> ownAddr_reg == $past(programmedBusAddress))
    else $error("programmed address not used");
  a_addr_ack: assert property (@(negedge sclClk) disable iff (!linkRstN)
    (bitCnt_reg == ACK_SLOT && state_reg == ST_ADDR) |=> sdaOe_reg == $past(addrHit))
    else $error("address acknowledge wrong");
  a_write_ack: assert property (@(negedge sclClk) disable iff (!linkRstN)
    (bitCnt_reg == ACK_SLOT && state_reg == ST_WDATA) |=> sdaOe_reg)
    else $error("write byte not acknowledged");
  a_index_step: assert property (@(posedge sclClk) disable iff (!linkRstN)
    (bitCnt_reg == ACK_SLOT && state_reg == ST_WDATA) |=> index_reg == $past(index_reg) + 8'h01)
    else $error("index did not advance");
  a_read_nack: assert property (@(posedge sclClk) disable iff (!linkRstN)
    (bitCnt_reg == ACK_SLOT && state_reg == ST_RDATA && sdaIn) |=> state_reg == ST_IGNORE)
    else $error("NACK did not end read");
  a_cur_read: assert property (@(posedge sclClk) disable iff (!linkRstN)
    (bitCnt_reg == ACK_SLOT && state_reg == ST_ADDR && addrHit && shift_reg[0])
    |=> rdIndexHold_reg == $past(index_reg))
    else $error("read did not use retained index");
  a_write_strobe: assert property (@(posedge clk_sys) disable iff (!rstn)
    $changed(wrSmp_reg) |=> regWrEn_reg ##1 !regWrEn_reg)
    else $error("write strobe missing");
  a_read_capture: assert property (@(posedge clk_sys) disable iff (!rstn)
    regRdEn_reg |=> rdHold_reg == $past(regRdData))
    else $error("read data not captured");
  c_write: cover property (@(posedge clk_sys) disable iff (!rstn) regWrEn_reg);
  c_read: cover property (@(posedge clk_sys) disable iff (!rstn) regRdEn_reg);
  c_addr_miss: cover property (@(posedge sclClk) disable iff (!linkRstN)
    bitCnt_reg == ACK_SLOT && state_reg == ST_ADDR && !addrHit);
  c_stop: cover property (@(posedge clk_sys) disable iff (!rstn) busStop);
endmodule // control_bus_slave_port
`default_nettype wire

/* File: tb/ctl_bus_master.sv */
// Host controller model: makes SCL, pulls SDA low or lets it go
`timescale 1ns/1ps
`default_nettype none
module ctl_bus_master
(
  output logic      sclClk,
  output logic      pullLow,
  input  wire logic sdaLine
);
  // Idle bus: clock stands high, data released to the pull-up
  initial
  begin
    sclClk = 1'b1;
    pullLow = 1'b0;
  end
  // One bit slot; data only pulled low or released
  task automatic bit_slot(input logic v, output logic s);
    #16 pullLow = ~v;
    #16 sclClk = 1'b1;
    #16 s = sdaLine;
    #16 sclClk = 1'b0;
  endtask
  // SDA falls while SCL high; long high phase keeps sync margin
  task automatic start_cond();
    #16.3 pullLow = 1'b0;
    #16 sclClk = 1'b1;
    #48 pullLow = 1'b1;
    #48 sclClk = 1'b0;
  endtask
  // SDA rises while SCL high, clock then stands high
  task automatic stop_cond();
    #16 pullLow = 1'b1;
    #16 sclClk = 1'b1;
    #48 pullLow = 1'b0;
    #48;
  endtask
  // Byte MSB first, then the acknowledge slot released
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_slot(b[i], s);
    bit_slot(1'b1, s);
    ack = ~s;
  endtask
  // Read byte, then ACK for more or NACK to end
  task automatic recv_byte(input logic more, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_slot(1'b1, s);
      b[i] = s;
    end
    bit_slot(~more, s);
  endtask
endmodule // ctl_bus_master
`default_nettype wire

/* File: tb/tb.sv */
// Testbench for the control bus slave port
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ctl_bus_pkg::*;
  logic       clk_sys = 1'b0;
  logic       rstn = 1'b1;
  logic [1:0] addrSelectPins = 2'h0;
  logic       addrSourceFromRegister = 1'b0;
  logic [6:0] programmedBusAddress = PROG_ADDR_RESET;
  logic       sclClk, pullLow, sdaOut, sdaOe, sdaIn, regWrEn, regRdEn, ack;
  logic [7:0] regRdIndex, rd;
  reg_wr_t    regWr;
  logic [7:0] mem [256];
  int         numErrors = 0;
  int         cmpCount = 0;

  always #2.5 clk_sys = ~clk_sys;
  // Wired-AND data line with pull-up
  assign sdaIn = ~(pullLow | sdaOe);
  // Register file beside the port, combinational read
  always @(posedge clk_sys)
    if (regWrEn === 1'b1)
      mem[regWr.index] <= regWr.data;
  logic [7:0] regRdData;
  assign regRdData = mem[regRdIndex];

  control_bus_slave_port control_bus_slave_port_i (.clk_sys(clk_sys), .rstn(rstn), .sclClk(sclClk),
    .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .addrSelectPins(addrSelectPins),
    .addrSourceFromRegister(addrSourceFromRegister), .programmedBusAddress(programmedBusAddress),
    .regWrEn(regWrEn), .regWr(regWr), .regRdEn(regRdEn), .regRdIndex(regRdIndex), .regRdData(regRdData));
  ctl_bus_master ctl_bus_master_i (.sclClk(sclClk), .pullLow(pullLow), .sdaLine(sdaIn));

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmpCount++;
    if (seen !== exp)
    begin
      $display("ERROR %s expected %h seen %h", what, exp, seen);
      numErrors++;
    end
  endtask
  task automatic close_out();
    if (numErrors == 0 && cmpCount > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Open drain: the driven value is never high
  always @(posedge clk_sys)
    if (rstn)
      check("sdaOut", {7'h0, sdaOut}, 8'h00);
  // Watchdog against a hung run
  initial
  begin
    #400000;
    numErrors++;
    close_out();
  end
  // START plus address byte
  task automatic frame(input logic [6:0] a, input logic rdDir);
    ctl_bus_master_i.start_cond();
    ctl_bus_master_i.send_byte({a, rdDir}, ack);
  endtask
  task automatic t_reset();
    check("sdaOe rst", {7'h0, sdaOe}, 8'h00);
    check("regWrEn rst", {7'h0, regWrEn}, 8'h00);
    check("regRdIndex rst", regRdIndex, INDEX_RESET);
  endtask
  // Current read straight after reset starts at index zero
  task automatic t_first_read();
    frame(ADDR_SEL_00, 1'b1);
    check("ack rd", {7'h0, ack}, 8'h01);
    ctl_bus_master_i.recv_byte(1'b0, rd);
    ctl_bus_master_i.stop_cond();
    check("first byte", rd, 8'ha5);
  endtask
  // Every strap code, own address acked, neighbour refused
  task automatic t_straps();
    logic [6:0] tbl [4] = '{7'h3c, 7'h3d, 7'h36, 7'h37};
    for (int s = 0; s < 4; s++)
    begin
      @(posedge clk_sys) addrSelectPins <= s[1:0];
      repeat (4) @(posedge clk_sys);
      frame(tbl[s], 1'b0);
      ctl_bus_master_i.stop_cond();
      check("strap ack", {7'h0, ack}, 8'h01);
      frame(tbl[s] ^ 7'h01, 1'b0);
      ctl_bus_master_i.stop_cond();
      check("wrong addr", {7'h0, ack}, 8'h00);
    end
    @(posedge clk_sys) addrSelectPins <= 2'h0;
  endtask
  // Sequential write lands on consecutive indexes
  task automatic t_seq_write();
    logic [7:0] d [3] = '{8'h11, 8'h22, 8'h33};
    frame(ADDR_SEL_00, 1'b0);
    ctl_bus_master_i.send_byte(8'h40, ack);
    check("index ack", {7'h0, ack}, 8'h01);
    for (int i = 0; i < 3; i++)
    begin
      ctl_bus_master_i.send_byte(d[i], ack);
      check("data ack", {7'h0, ack}, 8'h01);
    end
    ctl_bus_master_i.stop_cond();
    for (int i = 0; i < 3; i++)
      check("mem", mem[8'h40 + i], d[i]);
  endtask
  // Random read through repeated START, then current read after it
  task automatic t_rand_read();
    frame(ADDR_SEL_00, 1'b0);
    ctl_bus_master_i.send_byte(8'h41, ack);
    frame(ADDR_SEL_00, 1'b1);
    check("rd ack", {7'h0, ack}, 8'h01);
    ctl_bus_master_i.recv_byte(1'b1, rd);
    check("rd 0", rd, 8'h22);
    ctl_bus_master_i.recv_byte(1'b0, rd);
    check("rd 1", rd, 8'h33);
    ctl_bus_master_i.stop_cond();
    frame(ADDR_SEL_00, 1'b1);
    ctl_bus_master_i.recv_byte(1'b0, rd);
    ctl_bus_master_i.stop_cond();
    check("cur rd", rd, 8'h43 ^ 8'ha5);
  endtask
  // Programmed address replaces the strap address
  task automatic t_prog_addr();
    @(posedge clk_sys) addrSourceFromRegister <= 1'b1;
    repeat (4) @(posedge clk_sys);
    frame(PROG_ADDR_RESET, 1'b0);
    ctl_bus_master_i.stop_cond();
    check("prog ack", {7'h0, ack}, 8'h01);
    frame(ADDR_SEL_00, 1'b0);
    ctl_bus_master_i.stop_cond();
    check("strap off", {7'h0, ack}, 8'h00);
    @(posedge clk_sys) addrSourceFromRegister <= 1'b0;
  endtask

  initial
  begin
    rstn <= 1'b0;
    for (int i = 0; i < 256; i++)
      mem[i] = i[7:0] ^ 8'ha5;
    repeat (20) @(posedge clk_sys);
    t_reset();
    rstn <= 1'b1;
    repeat (8) @(posedge clk_sys);
    t_first_read();
    t_straps();
    t_seq_write();
    t_rand_read();
    t_prog_addr();
    close_out();
  end
endmodule // tb
`default_nettype wire
